// [design/drive_condition_detectors.sv]
// Purpose: Overload warning, current detection, low torque and command loss detection.
// Assumes: Measurements are synchronous to clk; command level is taken before input filtering.
// Notes: Registers sit on a zero-wait APB slave; read data is captured in the setup cycle.
// Overview of operation
// RULE1 - Overload warning is on while output current exceeds the current level setting.
// RULE2 - Operator should set current level near 80 to 90 percent of thermal level.
// RULE3 - A terminal shows the overload warning only when its function code is 7.
// RULE4 - Current detected sets after current stays above level longer than current timer.
// RULE5 - Current detected clears when current drops below 90 percent of the level.
// RULE6 - Current detected stays on at least 100 ms per assertion.
// RULE7 - A terminal shows current detected only when its function code is 37.
// RULE8 - Command below 10 percent of sample within 400 ms declares loss; run at ratio.
// RULE9 - Command rising above the recovery threshold ends loss and follows the command again.
// RULE10 - Loss level 999 still flags loss but keeps the analog command as reference.
// RULE11 - Loss level 0 or 999 uses sampled level times 0.2 as recovery threshold.
// RULE12 - Loss level 100 percent or more uses sampled level times one as threshold.
// RULE13 - Command level is re-sampled at fixed intervals for continuous loss monitoring.
// RULE14 - Loss detection uses the unfiltered command, independent of filter constants.
// RULE15 - Low torque sets after torque stays below level longer than torque timer.
// RULE16 - Low torque clears when torque rises above the level plus 5 percent.
// RULE17 - Low torque stays on at least 100 ms per assertion.
// RULE18 - A terminal shows low torque only when its function code is 45.
// RULE19 - Torque level is in percent, 100 meaning rated motor torque.
// RULE20 - Below 20 percent of base frequency low torque detection holds its result.
// RULE21 - Low torque is forced off whenever the drive is stopped.
// RULE22 - Command loss flag clears once analog command operation resumes normally.
// RULE23 - All timers count a millisecond tick from the clock and clear on reset.
`timescale 1ns/1ns
module drive_condition_detectors
   import drive_det_pkg::*;
#(
   parameter int MS_CYC = MS_CYCLES
)
(
   input wire logic clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [AW-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire meas_t meas,
   output logic overload_warning,
   output logic current_detected,
   output logic low_torque_flag,
   output logic command_loss,
   output logic [DW-1:0] freq_ref,
   output logic [TERM_COUNT-1:0] term_out
);
   localparam logic [23:0] MS_LAST = 24'(MS_CYC - 1);

   state_t s_q;
   state_t s_d;

   // Multiplies a level by a small constant without losing the top bits.
   function automatic logic [DW+7:0] mul8(input logic [DW-1:0] x, input logic [7:0] k);
      logic [DW+7:0] xe;
      logic [DW+7:0] ke;
      xe = {8'h00, x};
      ke = {{DW{1'b0}}, k};
      return xe * ke;
   endfunction

   // Full-width product of two levels.
   function automatic logic [2*DW-1:0] mul16(input logic [DW-1:0] a, input logic [DW-1:0] b);
      logic [2*DW-1:0] ae;
      logic [2*DW-1:0] be;
      ae = {{DW{1'b0}}, a};
      be = {{DW{1'b0}}, b};
      return ae * be;
   endfunction

   // Saturating increment for millisecond counters.
   function automatic logic [DW-1:0] inc_sat(input logic [DW-1:0] c);
      return (c == {DW{1'b1}}) ? c : c + 16'h0001;
   endfunction

   // Decodes the terminal selection register index for an address.
   function automatic logic term_hit(input logic [AW-1:0] a, input int i);
      return a == ADDR_TERM_BASE + AW'(4 * i);
   endfunction

   logic [2*DW-1:0] ratio_prod;
   logic [2*DW-1:0] ratio_q;
   logic [2*DW-1:0] recov_lhs;
   logic [2*DW-1:0] recov_rhs;
   logic recovered;
   logic drop_seen;
   logic low_speed;
   logic wr_en;
   logic rd_setup;
   logic mapped;

   // Command loss comparisons on the unfiltered command level.
   always_comb
   begin
      ratio_prod = mul16(s_q.sampled_command_level, s_q.loss_level_setting);
      ratio_q = ratio_prod / {{DW{1'b0}}, PCT_FULL};
      drop_seen = (s_q.sampled_command_level != '0) &&
                  (mul8(meas.cmd_level, K_TEN) < {8'h00, s_q.sampled_command_level}); // RULE8 RULE14
      recov_lhs = mul16(meas.cmd_level, PCT_FULL);
      recov_rhs = mul16(s_q.sampled_command_level, s_q.loss_level_setting);
      if ((s_q.loss_level_setting == '0) || (s_q.loss_level_setting == LOSS_DISABLED))
      begin
         recovered = mul8(meas.cmd_level, K_FIVE) > {8'h00, s_q.sampled_command_level}; // RULE11
      end
      else if (s_q.loss_level_setting >= PCT_FULL)
      begin
         recovered = meas.cmd_level > s_q.sampled_command_level; // RULE12
      end
      else
      begin
         recovered = recov_lhs > recov_rhs; // RULE9
      end
   end

   // Low frequency window where torque estimates are unreliable.
   assign low_speed = mul8(meas.out_freq, K_FIVE) < {8'h00, s_q.base_frequency_setting}; // RULE20

   // APB strobes and address decode.
   always_comb
   begin
      wr_en = psel && penable && pwrite;
      rd_setup = psel && !penable;
      mapped = (paddr == ADDR_CUR_LEVEL) || (paddr == ADDR_CUR_TIMER) ||
               (paddr == ADDR_LOSS_LEVEL) || (paddr == ADDR_TRQ_LEVEL) ||
               (paddr == ADDR_TRQ_TIMER) || (paddr == ADDR_BASE_FREQ) ||
               (paddr == ADDR_STATUS) || (paddr == ADDR_FREQ_REF);
      for (int i = 0; i < TERM_COUNT; i++)
      begin
         if (term_hit(paddr, i))
         begin
            mapped = 1'b1;
         end
      end
   end

   // Next state for registers, timers and detectors.
   always_comb
   begin
      s_d = s_q;

      // Millisecond tick shared by every timer.
      s_d.tick = 1'b0;
      if (s_q.ms_cnt == MS_LAST)
      begin
         s_d.ms_cnt = '0;
         s_d.tick = 1'b1; // RULE23
      end
      else
      begin
         s_d.ms_cnt = s_q.ms_cnt + 24'h000001;
      end

      // Register writes take effect in the access phase.
      if (wr_en)
      begin
         unique case (paddr)
            ADDR_CUR_LEVEL: s_d.current_level_setting = pwdata[DW-1:0];
            ADDR_CUR_TIMER: s_d.current_timer_setting = pwdata[DW-1:0];
            ADDR_LOSS_LEVEL: s_d.loss_level_setting = pwdata[DW-1:0];
            ADDR_TRQ_LEVEL: s_d.torque_level_setting = pwdata[DW-1:0]; // RULE19
            ADDR_TRQ_TIMER: s_d.torque_timer_setting = pwdata[DW-1:0];
            ADDR_BASE_FREQ: s_d.base_frequency_setting = pwdata[DW-1:0];
            default:
            begin
               for (int i = 0; i < TERM_COUNT; i++)
               begin
                  if (term_hit(paddr, i))
                  begin
                     s_d.term_sel[i] = pwdata[7:0];
                  end
               end
            end
         endcase
      end

      // Read data and error are captured in the setup cycle.
      if (rd_setup)
      begin
         s_d.pslverr = !mapped;
         s_d.prdata = '0;
         unique case (paddr)
            ADDR_CUR_LEVEL: s_d.prdata[DW-1:0] = s_q.current_level_setting;
            ADDR_CUR_TIMER: s_d.prdata[DW-1:0] = s_q.current_timer_setting;
            ADDR_LOSS_LEVEL: s_d.prdata[DW-1:0] = s_q.loss_level_setting;
            ADDR_TRQ_LEVEL: s_d.prdata[DW-1:0] = s_q.torque_level_setting;
            ADDR_TRQ_TIMER: s_d.prdata[DW-1:0] = s_q.torque_timer_setting;
            ADDR_BASE_FREQ: s_d.prdata[DW-1:0] = s_q.base_frequency_setting;
            ADDR_STATUS: s_d.prdata = {s_q.sampled_command_level, 12'h000, s_q.fl};
            ADDR_FREQ_REF: s_d.prdata[DW-1:0] = s_q.freq_ref;
            default:
            begin
               for (int i = 0; i < TERM_COUNT; i++)
               begin
                  if (term_hit(paddr, i))
                  begin
                     s_d.prdata[7:0] = s_q.term_sel[i];
                  end
               end
            end
         endcase
      end

      // Overload early warning follows the current directly.
      s_d.fl.overload_warning = meas.current > s_q.current_level_setting; // RULE1

      // Current detection with on-delay, minimum width and 90 percent release.
      if (meas.current <= s_q.current_level_setting)
      begin
         s_d.cur_cnt = '0;
      end
      else if (s_q.tick)
      begin
         s_d.cur_cnt = inc_sat(s_q.cur_cnt);
      end
      if (s_q.fl.current_detected)
      begin
         if (s_q.tick)
         begin
            s_d.cur_min = inc_sat(s_q.cur_min);
         end
         if ((s_q.cur_min >= MIN_ON_MS) && // RULE6
             (mul8(meas.current, K_TEN) < mul8(s_q.current_level_setting, K_NINE))) // RULE5
         begin
            s_d.fl.current_detected = 1'b0;
         end
      end
      else if (s_q.cur_cnt > s_q.current_timer_setting)
      begin
         s_d.fl.current_detected = 1'b1; // RULE4
         s_d.cur_min = '0;
      end

      // Low torque detection, held at low speed and cleared when stopped.
      if (!meas.running)
      begin
         s_d.fl.low_torque_flag = 1'b0; // RULE21
         s_d.trq_cnt = '0;
         s_d.trq_min = '0;
      end
      else if (!low_speed)
      begin
         if (meas.torque >= s_q.torque_level_setting)
         begin
            s_d.trq_cnt = '0;
         end
         else if (s_q.tick)
         begin
            s_d.trq_cnt = inc_sat(s_q.trq_cnt);
         end
         if (s_q.fl.low_torque_flag)
         begin
            if (s_q.tick)
            begin
               s_d.trq_min = inc_sat(s_q.trq_min);
            end
            if ((s_q.trq_min >= MIN_ON_MS) && // RULE17
                ({1'b0, meas.torque} > {1'b0, s_q.torque_level_setting} + {1'b0, TRQ_HYST})) // RULE16
            begin
               s_d.fl.low_torque_flag = 1'b0;
            end
         end
         else if (s_q.trq_cnt > s_q.torque_timer_setting)
         begin
            s_d.fl.low_torque_flag = 1'b1; // RULE15
            s_d.trq_min = '0;
         end
      end
      else if (s_q.fl.low_torque_flag && s_q.tick)
      begin
         s_d.trq_min = inc_sat(s_q.trq_min); // RULE20
      end

      // Command loss: periodic sampling, drop detection and recovery.
      if (s_q.tick)
      begin
         s_d.win_cnt = inc_sat(s_q.win_cnt);
      end
      if (!s_q.fl.command_loss)
      begin
         if (drop_seen)
         begin
            s_d.fl.command_loss = 1'b1; // RULE8
         end
         else if (s_q.tick && (s_q.win_cnt >= LOSS_WIN_MS - 16'h0001))
         begin
            s_d.sampled_command_level = meas.cmd_level; // RULE13
            s_d.win_cnt = '0;
         end
      end
      else if (recovered)
      begin
         s_d.fl.command_loss = 1'b0; // RULE22
         s_d.sampled_command_level = meas.cmd_level;
         s_d.win_cnt = '0;
      end

      // Reference frequency substitution during command loss.
      if (s_q.fl.command_loss && (s_q.loss_level_setting != LOSS_DISABLED)) // RULE10
      begin
         s_d.freq_ref = (ratio_q[2*DW-1:DW] != '0) ? {DW{1'b1}} : ratio_q[DW-1:0]; // RULE8
      end
      else
      begin
         s_d.freq_ref = meas.cmd_level; // RULE9
      end

      // Output terminal routing by function code.
      for (int i = 0; i < TERM_COUNT; i++)
      begin
         unique case (s_q.term_sel[i])
            FN_OVERLOAD: s_d.term_out[i] = s_q.fl.overload_warning; // RULE3
            FN_CUR_DET: s_d.term_out[i] = s_q.fl.current_detected; // RULE7
            FN_LOW_TRQ: s_d.term_out[i] = s_q.fl.low_torque_flag; // RULE18
            FN_CMD_LOSS: s_d.term_out[i] = s_q.fl.command_loss;
            default: s_d.term_out[i] = 1'b0;
         endcase
      end
   end

   // State register with synchronous reset.
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         s_q <= '0; // RULE23
         s_q.current_level_setting <= RST_CUR_LEVEL;
         s_q.current_timer_setting <= RST_CUR_TIMER;
         s_q.loss_level_setting <= RST_LOSS_LEVEL;
         s_q.torque_level_setting <= RST_TRQ_LEVEL;
         s_q.torque_timer_setting <= RST_TRQ_TIMER;
         s_q.base_frequency_setting <= RST_BASE_FREQ;
         s_q.term_sel <= {TERM_COUNT{RST_TERM_SEL}};
      end
      else
      begin
         s_q <= s_d;
      end
   end

   // Outputs.
   assign prdata = s_q.prdata;
   assign pslverr = s_q.pslverr && psel && penable;
   assign pready = 1'b1;
   assign overload_warning = s_q.fl.overload_warning;
   assign current_detected = s_q.fl.current_detected;
   assign low_torque_flag = s_q.fl.low_torque_flag;
   assign command_loss = s_q.fl.command_loss;
   assign freq_ref = s_q.freq_ref;
   assign term_out = s_q.term_out;
endmodule

// [design/drive_det_pkg.sv]
// Purpose: Shared constants and carrier types for the drive condition detectors.
// Assumes: 125 MHz system clock, APB register access with 32-bit data.
// Notes: Levels are 16-bit; torque is in percent of rated torque.
package drive_det_pkg;
   localparam int DW = 16;
   localparam int TERM_COUNT = 2;
   localparam int AW = 8;

   // Register byte addresses.
   localparam logic [AW-1:0] ADDR_CUR_LEVEL = 8'h00;
   localparam logic [AW-1:0] ADDR_CUR_TIMER = 8'h04;
   localparam logic [AW-1:0] ADDR_LOSS_LEVEL = 8'h08;
   localparam logic [AW-1:0] ADDR_TRQ_LEVEL = 8'h0C;
   localparam logic [AW-1:0] ADDR_TRQ_TIMER = 8'h10;
   localparam logic [AW-1:0] ADDR_BASE_FREQ = 8'h14;
   localparam logic [AW-1:0] ADDR_TERM_BASE = 8'h18;
   localparam logic [AW-1:0] ADDR_STATUS = 8'h30;
   localparam logic [AW-1:0] ADDR_FREQ_REF = 8'h34;

   // Register reset values.
   localparam logic [DW-1:0] RST_CUR_LEVEL = 16'h0064;
   localparam logic [DW-1:0] RST_CUR_TIMER = 16'h000A;
   localparam logic [DW-1:0] RST_LOSS_LEVEL = 16'h03E7;
   localparam logic [DW-1:0] RST_TRQ_LEVEL = 16'h0014;
   localparam logic [DW-1:0] RST_TRQ_TIMER = 16'h000A;
   localparam logic [DW-1:0] RST_BASE_FREQ = 16'h0258;
   localparam logic [7:0] RST_TERM_SEL = 8'h00;

   // Output terminal function codes.
   localparam logic [7:0] FN_OVERLOAD = 8'h07;
   localparam logic [7:0] FN_CMD_LOSS = 8'h21;
   localparam logic [7:0] FN_CUR_DET = 8'h25;
   localparam logic [7:0] FN_LOW_TRQ = 8'h2D;

   // Loss level codes and ratios.
   localparam logic [DW-1:0] LOSS_DISABLED = 16'h03E7;
   localparam logic [DW-1:0] PCT_FULL = 16'h0064;
   localparam logic [7:0] K_TEN = 8'h0A;
   localparam logic [7:0] K_NINE = 8'h09;
   localparam logic [7:0] K_FIVE = 8'h05;
   localparam logic [DW-1:0] TRQ_HYST = 16'h0005;

   // Timing.
   localparam int CLK_PERIOD_NS = 8;
   localparam int MS_NS = 1000000;
   localparam int MS_CYCLES = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [DW-1:0] MIN_ON_MS = 16'h0064;
   localparam logic [DW-1:0] LOSS_WIN_MS = 16'h0190;

   // Internal measurements.
   typedef struct packed {
      logic [DW-1:0] current;
      logic [DW-1:0] torque;
      logic [DW-1:0] cmd_level;
      logic [DW-1:0] out_freq;
      logic running;
   } meas_t;

   // Detection flags.
   typedef struct packed {
      logic overload_warning;
      logic current_detected;
      logic low_torque_flag;
      logic command_loss;
   } flags_t;

   // Whole module state.
   typedef struct packed {
      logic [DW-1:0] current_level_setting;
      logic [DW-1:0] current_timer_setting;
      logic [DW-1:0] loss_level_setting;
      logic [DW-1:0] torque_level_setting;
      logic [DW-1:0] torque_timer_setting;
      logic [DW-1:0] base_frequency_setting;
      logic [TERM_COUNT-1:0][7:0] term_sel;
      logic [23:0] ms_cnt;
      logic tick;
      logic [DW-1:0] cur_cnt;
      logic [DW-1:0] cur_min;
      logic [DW-1:0] trq_cnt;
      logic [DW-1:0] trq_min;
      logic [DW-1:0] win_cnt;
      logic [DW-1:0] sampled_command_level;
      flags_t fl;
      logic [DW-1:0] freq_ref;
      logic [TERM_COUNT-1:0] term_out;
      logic [31:0] prdata;
      logic pslverr;
   } state_t;
endpackage

// [dv/drive_condition_detectors_monitor.sv]
// Purpose: Port-level checks for the drive condition detectors.
// Assumes: One clock; rst is synchronous and active high.
// Notes: Current and torque level settings and terminal 0 code are shadowed from APB writes.
`timescale 1ns/1ns
module drive_condition_detectors_monitor
   import drive_det_pkg::*;
#(
   parameter int MS_CYC = MS_CYCLES
)
(
   input wire logic clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [AW-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire meas_t meas,
   input wire logic overload_warning,
   input wire logic current_detected,
   input wire logic low_torque_flag,
   input wire logic command_loss,
   input wire logic [DW-1:0] freq_ref,
   input wire logic [TERM_COUNT-1:0] term_out
);
   logic [DW-1:0] lvl_q;
   logic [DW-1:0] tlvl_q;
   logic [7:0] code_q;
   logic [31:0] cd_n_q;
   logic [31:0] lt_n_q;
   logic wr;
   logic sel0;
   // A write lands at the access edge.
   assign wr = psel && penable && pwrite;
   // Flag that terminal 0 should show for its code.
   always_comb
   begin
      case (code_q)
         FN_OVERLOAD: sel0 = overload_warning;
         FN_CUR_DET: sel0 = current_detected;
         FN_LOW_TRQ: sel0 = low_torque_flag;
         FN_CMD_LOSS: sel0 = command_loss;
         default: sel0 = 1'b0;
      endcase
   end
   // Shadow settings and count how long current detected and low torque have been high.
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         lvl_q <= RST_CUR_LEVEL;
         tlvl_q <= RST_TRQ_LEVEL;
         code_q <= RST_TERM_SEL;
         cd_n_q <= '0;
         lt_n_q <= '0;
      end
      else
      begin
         if (wr && paddr == ADDR_CUR_LEVEL)
            lvl_q <= pwdata[DW-1:0];
         if (wr && paddr == ADDR_TRQ_LEVEL)
            tlvl_q <= pwdata[DW-1:0];
         if (wr && paddr == ADDR_TERM_BASE)
            code_q <= pwdata[7:0];
         cd_n_q <= current_detected ? cd_n_q + 1 : '0;
         lt_n_q <= low_torque_flag ? lt_n_q + 1 : '0;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   ovl_follow_a: assert property (!$past(rst) |-> overload_warning == $past(meas.current > lvl_q))
      else $error("overload warning does not follow current");
   cd_cause_a: assert property ($rose(current_detected) |-> $past(meas.current > lvl_q))
      else $error("current detected rose without high current");
   cd_release_a: assert property ($fell(current_detected) && !$past(rst)
      |-> $past(32'(meas.current) * 10 < 32'(lvl_q) * 9)) else $error("current detected fell too early");
   cd_min_width_a: assert property ($fell(current_detected) && !$past(rst) |-> cd_n_q >= 99 * MS_CYC)
      else $error("current detected pulse too short");
   term_route_a: assert property (!$past(rst) |-> term_out[0] == $past(sel0))
      else $error("terminal 0 shows the wrong flag");
   lt_stop_a: assert property (!meas.running |=> !low_torque_flag)
      else $error("low torque on while stopped");
   lt_min_width_a: assert property ($fell(low_torque_flag) && $past(meas.running) && !$past(rst)
      |-> lt_n_q >= 99 * MS_CYC) else $error("low torque pulse too short");
   lt_release_a: assert property ($fell(low_torque_flag) && $past(meas.running) && !$past(rst)
      |-> $past(meas.torque > tlvl_q + TRQ_HYST)) else $error("low torque fell below hysteresis");
   freq_follow_a: assert property (!command_loss && !$past(command_loss) && !$past(rst)
      |-> freq_ref == $past(meas.cmd_level)) else $error("reference does not follow command");
   cover property ($rose(current_detected));
   cover property ($rose(low_torque_flag));
   cover property ($rose(command_loss));
   cover property ($fell(command_loss));
endmodule

// [dv/relay_bank.sv]
// Purpose: External relays wired to the digital output terminals.
// Assumes: Contacts close two clocks after the terminal turns on.
// Notes: Observes only; drives nothing back into the block.
`timescale 1ns/1ns
module relay_bank
   import drive_det_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [TERM_COUNT-1:0] term_out,
   output logic [TERM_COUNT-1:0] closed
);
   logic [TERM_COUNT-1:0] coil_q;
   // Coil then contact stage, so contacts lag the terminal.
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         coil_q <= '0;
         closed <= '0;
      end
      else
      begin
         coil_q <= term_out;
         closed <= coil_q;
      end
   end
endmodule

// [dv/test_drive_condition_detectors.sv]
// Purpose: Self-checking bench for the drive condition detectors.
// Assumes: A millisecond is shortened to 10 clocks.
// Notes: Registers go over APB; relays watch the terminals.
`timescale 1ns/1ns
`define CHK(nm, ex, gt) begin total_checks++; if ((gt) !== (ex)) begin n_fail++; \
   $display("[ERR] %s exp %0h got %0h", nm, ex, gt); end end
module test_drive_condition_detectors
   import drive_det_pkg::*;
   ;
   localparam int MS = 10;
   logic clk;
   logic rst;
   logic psel;
   logic penable;
   logic pwrite;
   logic [AW-1:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   meas_t meas;
   logic overload_warning;
   logic current_detected;
   logic low_torque_flag;
   logic command_loss;
   logic [DW-1:0] freq_ref;
   logic [TERM_COUNT-1:0] term_out;
   logic [TERM_COUNT-1:0] closed;
   logic [3:0] fl;
   logic [31:0] rd;
   logic err;
   int n_fail;
   int total_checks;
   assign fl = {overload_warning, current_detected, low_torque_flag, command_loss};
   drive_condition_detectors #(.MS_CYC(MS)) drive_condition_detectors_i (.clk(clk), .rst(rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .meas(meas), .overload_warning(overload_warning), .current_detected(current_detected),
      .low_torque_flag(low_torque_flag), .command_loss(command_loss), .freq_ref(freq_ref), .term_out(term_out));
   relay_bank relay_bank_i (.clk(clk), .rst(rst), .term_out(term_out), .closed(closed));
   // Clock at 125 MHz.
   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   task automatic conclude();
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   // One APB transfer; returns just after a rising edge.
   task automatic apb(input logic w, input logic [AW-1:0] a, input logic [31:0] d);
      int i;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      i = 0;
      do
      begin
         @(posedge clk);
         i++;
      end
      while (pready !== 1'b1 && i < 20);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1)
      begin
         n_fail++;
         $display("[ERR] apb ready exp 1 got 0");
         conclude();
      end
   endtask
   task automatic wait_fl(input int b, input logic v, input int lim);
      int i;
      i = 0;
      total_checks++;
      while (fl[b] !== v && i < lim)
      begin
         @(posedge clk);
         i++;
      end
      if (fl[b] !== v)
      begin
         n_fail++;
         $display("[ERR] flag %0d exp %0b got %0b", b, v, fl[b]);
         conclude();
      end
   endtask
   task automatic check_regs();
      logic [AW-1:0] a [8];
      logic [31:0] e [8];
      a = '{ADDR_CUR_LEVEL, ADDR_CUR_TIMER, ADDR_LOSS_LEVEL, ADDR_TRQ_LEVEL, ADDR_TRQ_TIMER, ADDR_BASE_FREQ,
         ADDR_TERM_BASE, 8'h1C};
      e = '{RST_CUR_LEVEL, RST_CUR_TIMER, RST_LOSS_LEVEL, RST_TRQ_LEVEL, RST_TRQ_TIMER, RST_BASE_FREQ,
         RST_TERM_SEL, RST_TERM_SEL};
      for (int i = 0; i < 8; i++)
      begin
         apb(1'b0, a[i], 32'h0);
         `CHK("reset value", e[i], rd)
      end
      apb(1'b1, 8'h24, 32'h0000_00A5);
      `CHK("unmapped err", 1'b1, err)
      apb(1'b1, ADDR_STATUS, 32'hFFFF_FFFF);
      apb(1'b0, ADDR_STATUS, 32'h0);
      `CHK("status", 32'h0, rd)
   endtask
   task automatic sc_current();
      // Level 85 sits in the advised band of a thermal level of 100.
      apb(1'b1, ADDR_CUR_LEVEL, 32'h0000_0055);
      apb(1'b1, ADDR_TERM_BASE, {24'h0, FN_OVERLOAD});
      apb(1'b1, ADDR_TERM_BASE + 8'h04, {24'h0, FN_CUR_DET});
      meas.current <= 16'h0096;
      cyc(3);
      `CHK("ovl", 1'b1, overload_warning)
      cyc(5 * MS);
      `CHK("cd early", 1'b0, current_detected)
      wait_fl(2, 1'b1, 20 * MS);
      cyc(4);
      `CHK("relays", 2'b11, closed)
      meas.current <= 16'h0050;
      cyc(120 * MS);
      `CHK("cd hold", 1'b1, current_detected)
      `CHK("relays", 2'b10, closed)
      meas.current <= 16'h0046;
      wait_fl(2, 1'b0, 2 * MS);
      meas.current <= 16'h0096;
      wait_fl(2, 1'b1, 20 * MS);
      meas.current <= 16'h0000;
      cyc(60 * MS);
      `CHK("cd min", 1'b1, current_detected)
      wait_fl(2, 1'b0, 60 * MS);
   endtask
   task automatic sc_torque();
      apb(1'b1, ADDR_TERM_BASE, {24'h0, FN_LOW_TRQ});
      meas.torque <= 16'h000A;
      cyc(5 * MS);
      `CHK("lt early", 1'b0, low_torque_flag)
      wait_fl(1, 1'b1, 20 * MS);
      meas.torque <= 16'h0019;
      cyc(120 * MS);
      `CHK("lt hyst", 1'b1, low_torque_flag)
      `CHK("relay lt", 1'b1, closed[0])
      meas.torque <= 16'h001A;
      wait_fl(1, 1'b0, 2 * MS);
      meas.torque <= 16'h000A;
      wait_fl(1, 1'b1, 20 * MS);
      meas.torque <= 16'h0064;
      cyc(50 * MS);
      `CHK("lt min", 1'b1, low_torque_flag)
      meas.out_freq <= 16'h0064;
      cyc(120 * MS);
      `CHK("lt held", 1'b1, low_torque_flag)
      meas.running <= 1'b0;
      cyc(3);
      `CHK("lt stop", 1'b0, low_torque_flag)
      meas.running <= 1'b1;
      meas.torque <= 16'h000A;
      cyc(30 * MS);
      `CHK("lt low freq", 1'b0, low_torque_flag)
      meas.out_freq <= 16'h0258;
      meas.torque <= 16'h0064;
   endtask
   task automatic cmd_step(input logic [DW-1:0] c, input logic l, input logic [DW-1:0] f);
      meas.cmd_level <= c;
      wait_fl(0, l, 5 * MS);
      cyc(3);
      `CHK("freq_ref", f, freq_ref)
      `CHK("loss", l, command_loss)
   endtask
   task automatic sc_loss();
      int i;
      apb(1'b1, ADDR_TERM_BASE + 8'h04, {24'h0, FN_CMD_LOSS});
      apb(1'b1, ADDR_LOSS_LEVEL, 32'h0000_0032);
      i = 0;
      rd = '0;
      while (rd[31:16] !== 16'h03E8 && i < 20)
      begin
         cyc(50 * MS);
         apb(1'b0, ADDR_STATUS, 32'h0);
         i++;
      end
      `CHK("sample", 16'h03E8, rd[31:16])
      cmd_step(16'h0032, 1'b1, 16'h01F4);
      cyc(4);
      `CHK("relay loss", 1'b1, closed[1])
      cmd_step(16'h01F4, 1'b1, 16'h01F4);
      cmd_step(16'h0258, 1'b0, 16'h0258);
      apb(1'b1, ADDR_LOSS_LEVEL, {16'h0, LOSS_DISABLED});
      cmd_step(16'h0032, 1'b1, 16'h0032);
      cmd_step(16'h0078, 1'b1, 16'h0078);
      cmd_step(16'h0082, 1'b0, 16'h0082);
      apb(1'b1, ADDR_LOSS_LEVEL, 32'h0000_0096);
      cmd_step(16'h000A, 1'b1, 16'h00C3);
      cmd_step(16'h0082, 1'b1, 16'h00C3);
      cmd_step(16'h0083, 1'b0, 16'h0083);
      apb(1'b1, ADDR_LOSS_LEVEL, 32'h0000_0000);
      cmd_step(16'h000A, 1'b1, 16'h0000);
      cmd_step(16'h001A, 1'b1, 16'h0000);
      cmd_step(16'h001B, 1'b0, 16'h001B);
   endtask
   // Reset, then each scenario in turn.
   initial
   begin
      rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      meas = '{current: 16'h0, torque: 16'h0064, cmd_level: 16'h03E8, out_freq: 16'h0258, running: 1'b1};
      n_fail = 0;
      total_checks = 0;
      cyc(6);
      rst <= 1'b0;
      check_regs();
      sc_current();
      sc_torque();
      sc_loss();
      conclude();
   end
endmodule
bind drive_condition_detectors drive_condition_detectors_monitor #(.MS_CYC(MS_CYC)) drive_condition_detectors_monitor_i (
   .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .meas(meas), .overload_warning(overload_warning),
   .current_detected(current_detected), .low_torque_flag(low_torque_flag), .command_loss(command_loss),
   .freq_ref(freq_ref), .term_out(term_out));
